// [hw/dlp_wiper_ctrl.sv]
// Two-wire slave and wiper control for a dual 65-tap log attenuator
//
// Operation
// - two independent 8-bit wiper registers, each steering one 65-tap wiper
// - bits 0 to 5 pick taps 0 to 63, one dB per step
// - bit 6 set forces the mute tap 64 regardless of other bits
// - bit 7 is ignored when choosing the tap
// - register value zero selects the high terminal, no attenuation
// - both registers load 0x3F at reset and hold until written
// - serial port accepts traffic within 10 us of reset release
// - address select bits must match the three select pins
// - commands write channel 0, channel 1, or both at once
// - read returns current wiper register contents over the link
// - zero-crossing mode holds new values until the input crosses zero
// - control byte is 0101, select bits, direction; ack only on match
// - in zero-crossing mode apply anyway 50 ms after the write ack
// - with zero-crossing off, apply the wiper right after the ack
// - zero-crossing mode is on after reset
module dlp_wiper_ctrl #(
	parameter int ZC_TIMEOUT_CYC = dlp_pkg::ZC_WINDOW_CYC
) (
	// Clock and reset
	input  wire logic        CLK,
	input  wire logic        RST_N,
	// Two-wire link
	input  wire logic        SCL,
	input  wire logic        SDA_I,
	output logic             SDA_O,
	output logic             SDA_OE_N,
	// Address select pins
	input  wire logic        SELECT_PIN_BIT0,
	input  wire logic        SELECT_PIN_BIT1,
	input  wire logic        SELECT_PIN_BIT2,
	// Zero-crossing detector levels, high when terminals are equal
	input  wire logic        ZERO_CROSS_0,
	input  wire logic        ZERO_CROSS_1,
	// Wiper tap selects and mode
	output logic [6:0]       CHAN0_WIPER_TAP,
	output logic [6:0]       CHAN1_WIPER_TAP,
	output logic             ZC_ENABLED
);
	import dlp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Decoding functions

	function automatic logic [6:0] tap_of(input logic [7:0] v);
		logic [6:0] t;
		t = {1'b0, v[POS_MSB:POS_LSB]};
		if (v[MUTE_BIT]) begin
			t = TAP_MUTE;
		end
		return t;
	endfunction

	function automatic logic [1:0] cmd_mask(input logic [7:0] c);
		logic [1:0] m;
		case (c)
			CMD_WR_CH0:  m = 2'b01;
			CMD_WR_CH1:  m = 2'b10;
			CMD_WR_BOTH: m = 2'b11;
			default:     m = 2'b00;
		endcase
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and edge detection

	dlp_pins_t pins_raw;
	dlp_pins_t pin;
	dlp_pins_t prev_q;
	dlp_pins_t prev_d;
	logic      rise;
	logic      fall;
	logic      start;
	logic      stop;

	assign pins_raw = {SCL, SDA_I,
		SELECT_PIN_BIT2, SELECT_PIN_BIT1, SELECT_PIN_BIT0,
		ZERO_CROSS_1, ZERO_CROSS_0};

	dlp_sync u_sync (
		.CLK   (CLK),
		.RST_N (RST_N),
		.d     (pins_raw),
		.q     (pin)
	);

	always_comb begin
		prev_d = pin;
		rise   = pin.scl & ~prev_q.scl;
		fall   = ~pin.scl & prev_q.scl;
		start  = pin.scl & prev_q.scl & prev_q.sda & ~pin.sda;
		stop   = pin.scl & prev_q.scl & ~prev_q.sda & pin.sda;
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			prev_q <= PINS_RST;
		end else begin
			prev_q <= prev_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Serial protocol engine and wiper registers

	dlp_state_t       st_q,    st_d;
	logic [2:0]       cnt_q,   cnt_d;
	logic [7:0]       sh_q,    sh_d;
	logic             full_q,  full_d;
	logic             rw_q,    rw_d;
	logic [7:0]       cmd_q,   cmd_d;
	logic             oe_n_q,  oe_n_d;
	logic [7:0]       tx_q,    tx_d;
	logic             ptr_q,   ptr_d;
	logic             mack_q,  mack_d;
	logic             zc_en_q, zc_en_d;
	logic [1:0][7:0]  wiper_q, wiper_d;
	logic [1:0]       wr_mask;

	always_comb begin
		st_d    = st_q;
		cnt_d   = cnt_q;
		sh_d    = sh_q;
		full_d  = full_q;
		rw_d    = rw_q;
		cmd_d   = cmd_q;
		oe_n_d  = oe_n_q;
		tx_d    = tx_q;
		ptr_d   = ptr_q;
		mack_d  = mack_q;
		zc_en_d = zc_en_q;
		wiper_d = wiper_q;
		wr_mask = 2'b00;
		if (start) begin
			st_d   = ST_ADDR;
			cnt_d  = 3'd0;
			full_d = 1'b0;
			oe_n_d = 1'b1;
		end else if (stop) begin
			st_d   = ST_IDLE;
			cnt_d  = 3'd0;
			full_d = 1'b0;
			oe_n_d = 1'b1;
		end else begin
			case (st_q)
				ST_IDLE: begin
					oe_n_d = 1'b1;
				end
				ST_ADDR, ST_CMD, ST_DATA: begin
					if (rise && !full_q) begin
						sh_d  = {sh_q[6:0], pin.sda};
						cnt_d = cnt_q + 3'd1;
						if (cnt_q == 3'd7) begin
							full_d = 1'b1;
						end
					end
					if (fall && full_q) begin
						full_d = 1'b0;
						if (st_q == ST_ADDR) begin
							if (sh_q[7:1] == {CTRL_CODE, pin.sel}) begin
								oe_n_d = 1'b0;
								rw_d   = sh_q[0];
								st_d   = ST_ADDR_ACK;
							end else begin
								st_d = ST_IDLE;
							end
						end else if (st_q == ST_CMD) begin
							if (cmd_mask(sh_q) != 2'b00 ||
								sh_q == CMD_ZC_OFF || sh_q == CMD_ZC_ON) begin
								oe_n_d = 1'b0;
								cmd_d  = sh_q;
								st_d   = ST_CMD_ACK;
							end else begin
								st_d = ST_IDLE;
							end
						end else begin
							oe_n_d = 1'b0;
							st_d   = ST_DATA_ACK;
						end
					end
				end
				ST_ADDR_ACK: begin
					if (fall) begin
						if (rw_q) begin
							ptr_d  = 1'b0;
							oe_n_d = wiper_q[0][7];
							tx_d   = {wiper_q[0][6:0], 1'b1};
							st_d   = ST_TX;
						end else begin
							oe_n_d = 1'b1;
							st_d   = ST_CMD;
						end
					end
				end
				ST_CMD_ACK: begin
					if (fall) begin
						oe_n_d = 1'b1;
						st_d   = ST_DATA;
						if (cmd_q == CMD_ZC_OFF) begin
							zc_en_d = 1'b0;
							st_d    = ST_CMD;
						end else if (cmd_q == CMD_ZC_ON) begin
							zc_en_d = 1'b1;
							st_d    = ST_CMD;
						end
					end
				end
				ST_DATA_ACK: begin
					if (fall) begin
						oe_n_d  = 1'b1;
						st_d    = ST_DATA;
						wr_mask = cmd_mask(cmd_q);
						for (int i = 0; i < NUM_CHAN; i++) begin
							if (wr_mask[i]) begin
								wiper_d[i] = sh_q;
							end
						end
					end
				end
				ST_TX: begin
					if (rise && !full_q) begin
						cnt_d = cnt_q + 3'd1;
						if (cnt_q == 3'd7) begin
							full_d = 1'b1;
						end
					end
					if (fall) begin
						if (full_q) begin
							full_d = 1'b0;
							oe_n_d = 1'b1;
							st_d   = ST_TX_ACK;
						end else begin
							oe_n_d = tx_q[7];
							tx_d   = {tx_q[6:0], 1'b1};
						end
					end
				end
				ST_TX_ACK: begin
					if (rise) begin
						mack_d = ~pin.sda;
					end
					if (fall) begin
						if (mack_q) begin
							ptr_d  = ~ptr_q;
							oe_n_d = wiper_q[~ptr_q][7];
							tx_d   = {wiper_q[~ptr_q][6:0], 1'b1};
							st_d   = ST_TX;
						end else begin
							st_d = ST_IDLE;
						end
					end
				end
				default: begin
					st_d   = ST_IDLE;
					oe_n_d = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			st_q    <= ST_IDLE;
			cnt_q   <= 3'd0;
			sh_q    <= 8'h00;
			full_q  <= 1'b0;
			rw_q    <= 1'b0;
			cmd_q   <= 8'h00;
			oe_n_q  <= 1'b1;
			tx_q    <= 8'hFF;
			ptr_q   <= 1'b0;
			mack_q  <= 1'b0;
			zc_en_q <= 1'b1;
			wiper_q <= {WIPER_RST, WIPER_RST};
		end else begin
			st_q    <= st_d;
			cnt_q   <= cnt_d;
			sh_q    <= sh_d;
			full_q  <= full_d;
			rw_q    <= rw_d;
			cmd_q   <= cmd_d;
			oe_n_q  <= oe_n_d;
			tx_q    <= tx_d;
			ptr_q   <= ptr_d;
			mack_q  <= mack_d;
			zc_en_q <= zc_en_d;
			wiper_q <= wiper_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Per-channel wiper apply with zero-crossing window

	logic [1:0][6:0] tap_w;

	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
		dlp_chan_t ch_q;
		dlp_chan_t ch_d;

		always_comb begin
			ch_d = ch_q;
			if (wr_mask[c]) begin
				if (zc_en_q) begin
					ch_d.pend  = 1'b1;
					ch_d.timer = '0;
				end else begin
					ch_d.pend = 1'b0;
					ch_d.tap  = tap_of(wiper_d[c]);
				end
			end else if (ch_q.pend) begin
				if (pin.zc[c] || !zc_en_q ||
					ch_q.timer == TMR_W'(ZC_TIMEOUT_CYC - 1)) begin
					ch_d.pend = 1'b0;
					ch_d.tap  = tap_of(wiper_q[c]);
				end else begin
					ch_d.timer = ch_q.timer + 1'b1;
				end
			end
		end

		always_ff @(posedge CLK) begin
			if (!RST_N) begin
				ch_q <= CHAN_RST;
			end else begin
				ch_q <= ch_d;
			end
		end

		assign tap_w[c] = ch_q.tap;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	logic sda_o_q;

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sda_o_q <= 1'b0;
		end else begin
			sda_o_q <= 1'b0;
		end
	end

	assign SDA_O           = sda_o_q;
	assign SDA_OE_N        = oe_n_q;
	assign CHAN0_WIPER_TAP = tap_w[0];
	assign CHAN1_WIPER_TAP = tap_w[1];
	assign ZC_ENABLED      = zc_en_q;

endmodule

// [common/dlp_pkg.sv]
// Shared constants and types for the dual log attenuator wiper control
package dlp_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_PERIOD_NS    = 4;
	localparam int ZC_WINDOW_MS     = 50;
	localparam int ZC_WINDOW_CYC    = ZC_WINDOW_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int READY_US         = 10;
	localparam int READY_CYC        = READY_US * 1_000 / CLK_PERIOD_NS;
	localparam int TMR_W            = 24;

	////////////////////////////////////////////////////////////////////////
	// Wiper register layout
	localparam int NUM_CHAN         = 2;
	localparam int POS_LSB          = 0;
	localparam int POS_MSB          = 5;
	localparam int MUTE_BIT         = 6;
	localparam int SPARE_BIT        = 7;
	localparam logic [7:0] WIPER_RST = 8'h3F;
	localparam logic [6:0] TAP_MUTE  = 7'h40;
	localparam logic [6:0] TAP_RST   = 7'h3F;

	////////////////////////////////////////////////////////////////////////
	// Serial link control byte and commands
	localparam logic [3:0] CTRL_CODE   = 4'h5;
	localparam logic [7:0] CMD_WR_CH0  = 8'h10;
	localparam logic [7:0] CMD_WR_CH1  = 8'h11;
	localparam logic [7:0] CMD_WR_BOTH = 8'h12;
	localparam logic [7:0] CMD_ZC_OFF  = 8'h20;
	localparam logic [7:0] CMD_ZC_ON   = 8'h21;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [3:0] {
		ST_IDLE     = 4'b0000,
		ST_ADDR     = 4'b0001,
		ST_ADDR_ACK = 4'b0010,
		ST_CMD      = 4'b0011,
		ST_CMD_ACK  = 4'b0100,
		ST_DATA     = 4'b0101,
		ST_DATA_ACK = 4'b0110,
		ST_TX       = 4'b0111,
		ST_TX_ACK   = 4'b1000
	} dlp_state_t;

	typedef struct packed {
		logic             scl;
		logic             sda;
		logic [2:0]       sel;
		logic [1:0]       zc;
	} dlp_pins_t;

	typedef struct packed {
		logic             pend;
		logic [TMR_W-1:0] timer;
		logic [6:0]       tap;
	} dlp_chan_t;

	// Idle bus level, so no false link edge follows reset
	localparam dlp_pins_t PINS_RST = 7'h60;
	localparam dlp_chan_t CHAN_RST = {1'b0, 24'h00_0000, TAP_RST};

endpackage

// [hw/dlp_sync.sv]
// Two-flop synchroniser for pins from outside the clock domain
module dlp_sync (
	// Clock and reset
	input  wire logic                CLK,
	input  wire logic                RST_N,
	// Asynchronous pin levels and their synchronised copy
	input  wire dlp_pkg::dlp_pins_t  d,
	output dlp_pkg::dlp_pins_t       q
);
	import dlp_pkg::*;

	dlp_pins_t meta_q;
	dlp_pins_t sync_q;

	////////////////////////////////////////////////////////////////////////
	// Only the second stage is read outside
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			meta_q <= PINS_RST;
			sync_q <= PINS_RST;
		end else begin
			meta_q <= d;
			sync_q <= meta_q;
		end
	end

	assign q = sync_q;

endmodule

// [test/dlp_wiper_ctrl_assertions.sv]
// Port checker for the wiper control block
module dlp_wiper_ctrl_assertions #(
	parameter int ZC_TIMEOUT_CYC = 200
) (
	// Clock and reset
	input wire logic       CLK,
	input wire logic       RST_N,
	// Link
	input wire logic       SCL,
	input wire logic       SDA_O,
	input wire logic       SDA_OE_N,
	// Taps and mode
	input wire logic [6:0] CHAN0_WIPER_TAP,
	input wire logic [6:0] CHAN1_WIPER_TAP,
	input wire logic       ZC_ENABLED
);
	timeunit 1ns;
	timeprecision 100ps;
	import dlp_pkg::*;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	////////////////////////////////////////////////////////////////////
	// Settled in the low phase after an SCL fall
	sequence s_low;
		!SCL && !$past(SCL, 2);
	endsequence

	AST_RESET_STATE: assert property ($rose(RST_N) |->
		CHAN0_WIPER_TAP == TAP_RST && CHAN1_WIPER_TAP == TAP_RST
		&& ZC_ENABLED && SDA_OE_N) else $error("reset state");
	AST_TAP_RANGE: assert property (
		CHAN0_WIPER_TAP <= TAP_MUTE && CHAN1_WIPER_TAP <= TAP_MUTE)
		else $error("tap range");
	AST_OPEN_DRAIN: assert property (SDA_O == 1'b0)
		else $error("sda driven high");
	AST_SDA_STABLE: assert property (
		SCL && $past(SCL, 3) |-> $stable(SDA_OE_N))
		else $error("sda moved in high phase");
	AST_SDA_MOVE: assert property ($changed(SDA_OE_N) |-> s_low)
		else $error("sda moved early");
	AST_ACK_HOLD: assert property (
		$fell(SDA_OE_N) |=> !SDA_OE_N [*4])
		else $error("low drive too short");
	AST_TAP_AFTER_ACK: assert property (
		!ZC_ENABLED && $changed({CHAN0_WIPER_TAP, CHAN1_WIPER_TAP})
		|-> s_low) else $error("tap moved off ack");
	AST_ZC_MODE: assert property ($changed(ZC_ENABLED) |-> s_low)
		else $error("mode moved off ack");
endmodule

bind dlp_wiper_ctrl dlp_wiper_ctrl_assertions #(
	.ZC_TIMEOUT_CYC(ZC_TIMEOUT_CYC)
) dlp_wiper_ctrl_assertions_i (
	.CLK(CLK), .RST_N(RST_N), .SCL(SCL), .SDA_O(SDA_O),
	.SDA_OE_N(SDA_OE_N), .CHAN0_WIPER_TAP(CHAN0_WIPER_TAP),
	.CHAN1_WIPER_TAP(CHAN1_WIPER_TAP), .ZC_ENABLED(ZC_ENABLED)
);

// [test/dlp_master.sv]
// Behavioural two-wire bus master
module dlp_master (
	// Clock
	input  wire logic CLK,
	// Resolved data line
	input  wire logic SDA,
	// Master lines
	output logic      SCL,
	output logic      SDA_LOW
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		SCL = 1'b1;
		SDA_LOW = 1'b0;
	end

	task automatic q(input int n);
		repeat (n) @(negedge CLK);
	endtask

	// Data falls while clock high
	task automatic start();
		q(10);
		SDA_LOW = 1'b1;
		q(10);
		SCL = 1'b0;
	endtask

	// Data rises while clock high
	task automatic stop();
		q(5);
		SDA_LOW = 1'b1;
		q(5);
		SCL = 1'b1;
		q(10);
		SDA_LOW = 1'b0;
		q(10);
	endtask

	// Data changes only in the low phase
	task automatic bit_io(input logic b, output logic r);
		q(5);
		SDA_LOW = ~b;
		q(5);
		SCL = 1'b1;
		q(5);
		r = SDA;
		q(5);
		SCL = 1'b0;
	endtask

	// MSB first, then the acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ack_in,
		output logic [7:0] rx, output logic nak);
		for (int i = 7; i >= 0; i--) begin
			bit_io(tx[i], rx[i]);
		end
		bit_io(ack_in, nak);
	endtask
endmodule

// [test/dlp_wiper_ctrl_test.sv]
// Self-checking bench for the wiper control block
module dlp_wiper_ctrl_test;
	timeunit 1ns;
	timeprecision 100ps;
	import dlp_pkg::*;

	localparam int ZCT = 200;
	localparam logic [2:0] SEL = 3'b101;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [2:0] sel = SEL;
	logic       zc0 = 1'b0;
	logic       zc1 = 1'b0;
	logic       scl, sda_low, sda_o, sda_oe_n, zc_en;
	logic [6:0] tap0, tap1;
	wire        sda = ~sda_low & (sda_oe_n | sda_o);
	int         n_mismatch = 0;
	int         checks = 0;

	always #2 clk = ~clk;

	dlp_master dlp_master_i (
		.CLK(clk), .SDA(sda), .SCL(scl), .SDA_LOW(sda_low)
	);
	dlp_wiper_ctrl #(.ZC_TIMEOUT_CYC(ZCT)) dlp_wiper_ctrl_i (
		.CLK(clk), .RST_N(rst_n), .SCL(scl), .SDA_I(sda),
		.SDA_O(sda_o), .SDA_OE_N(sda_oe_n), .SELECT_PIN_BIT0(sel[0]),
		.SELECT_PIN_BIT1(sel[1]), .SELECT_PIN_BIT2(sel[2]),
		.ZERO_CROSS_0(zc0), .ZERO_CROSS_1(zc1),
		.CHAN0_WIPER_TAP(tap0), .CHAN1_WIPER_TAP(tap1),
		.ZC_ENABLED(zc_en)
	);

	////////////////////////////////////////////////////////////////////
	task automatic cmp(input string what, input logic [7:0] exp, got);
		checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s exp %h got %h", what, exp, got);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	function automatic logic [7:0] tap_of(input logic [7:0] v);
		return v[6] ? 8'h40 : {2'b00, v[5:0]};
	endfunction

	task automatic send(input logic [7:0] b, output logic nak);
		logic [7:0] rx;
		dlp_master_i.xfer(b, 1'b1, rx, nak);
	endtask

	task automatic wr(input logic [7:0] cmd, d, input int n);
		logic nak;
		dlp_master_i.start();
		send({CTRL_CODE, SEL, 1'b0}, nak);
		cmp("addr ack", 8'h00, {7'h00, nak});
		send(cmd, nak);
		cmp("cmd ack", 8'h00, {7'h00, nak});
		if (n > 0) begin
			send(d, nak);
			cmp("data ack", 8'h00, {7'h00, nak});
		end
		dlp_master_i.stop();
	endtask

	task automatic regs(input logic [7:0] v0, v1);
		logic [7:0] a, b;
		logic       nak;
		cmp("tap0", tap_of(v0), {1'b0, tap0});
		cmp("tap1", tap_of(v1), {1'b0, tap1});
		dlp_master_i.start();
		send({CTRL_CODE, SEL, 1'b1}, nak);
		dlp_master_i.xfer(8'hFF, 1'b0, a, nak);
		dlp_master_i.xfer(8'hFF, 1'b1, b, nak);
		dlp_master_i.stop();
		cmp("read0", v0, a);
		cmp("read1", v1, b);
	endtask

	task automatic wait_tap(input int ch, input logic [6:0] e,
		input int lim, output int n);
		n = 0;
		while ((ch ? tap1 : tap0) !== e) begin
			@(negedge clk);
			n++;
			if (n > lim) begin
				n_mismatch++;
				$display("BAD tap wait exp %h", e);
				end_sim();
			end
		end
	endtask

	////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rst_n = 1'b0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
		cmp("zc mode", 8'h01, {7'h00, zc_en});
		regs(WIPER_RST, WIPER_RST);
		$display("test reset done");
	endtask

	task automatic t_select();
		logic nak;
		for (int i = 0; i < 9; i++) begin
			sel = (i < 8) ? i[2:0] : SEL;
			repeat (4) @(negedge clk);
			dlp_master_i.start();
			send({(i < 8) ? CTRL_CODE : 4'hA, SEL, 1'b0}, nak);
			cmp("sel ack", {7'h00, i != 5}, {7'h00, nak});
			dlp_master_i.stop();
		end
		dlp_master_i.start();
		send({CTRL_CODE, SEL, 1'b0}, nak);
		cmp("good addr", 8'h00, {7'h00, nak});
		send(8'h33, nak);
		cmp("bad cmd", 8'h01, {7'h00, nak});
		dlp_master_i.stop();
		$display("test select done");
	endtask

	task automatic t_direct();
		logic [7:0] v[6] = '{8'h06, 8'hC5, 8'h00, 8'h80, 8'h7F, 8'h3E};
		wr(CMD_ZC_OFF, 8'h00, 0);
		cmp("zc off", 8'h00, {7'h00, zc_en});
		foreach (v[i]) begin
			wr(CMD_WR_CH0, v[i], 1);
			wr(CMD_WR_CH1, ~v[i], 1);
			regs(v[i], ~v[i]);
		end
		wr(CMD_WR_BOTH, 8'h2A, 1);
		regs(8'h2A, 8'h2A);
		$display("test direct done");
	endtask

	task automatic t_zc();
		int n;
		wr(CMD_ZC_ON, 8'h00, 0);
		cmp("zc on", 8'h01, {7'h00, zc_en});
		wr(CMD_WR_CH0, 8'h10, 1);
		zc1 = 1'b1;
		repeat (50) @(negedge clk);
		cmp("held tap", 8'h2A, {1'b0, tap0});
		zc1 = 1'b0;
		zc0 = 1'b1;
		wait_tap(0, 7'h10, 8, n);
		zc0 = 1'b0;
		wr(CMD_WR_CH1, 8'h05, 1);
		wait_tap(1, 7'h05, ZCT, n);
		cmp("zc wait", 8'h01, {7'h00, n > ZCT - 40 && n < ZCT - 10});
		$display("test zero cross done");
	endtask

	initial begin
		t_reset();
		t_select();
		t_direct();
		t_zc();
		wr(CMD_ZC_OFF, 8'h00, 0);
		cmp("zc off pre reset", 8'h00, {7'h00, zc_en});
		t_reset();
		end_sim();
	end
endmodule
